//--- logic/lfcc_regs.svh
// register offsets, field positions and reset values of the panel control block
// assumes inclusion by bare name from design files
`ifndef LFCC_REGS_SVH
`define LFCC_REGS_SVH
`define LFCC_PANEL_CONTROL_OFS 4'h0
`define LFCC_SEL_LO_OFS 4'h1
`define LFCC_STATUS_OFS 4'h2
`define LFCC_RSVD_BIT 7
`define LFCC_PSW_BIT 6
`define LFCC_RUN_BIT 5
`define LFCC_SHOW_BIT 4
`define LFCC_CKS_MSB 3
`define LFCC_PANEL_CONTROL_RST 8'h80
`define LFCC_RSVD_MASK 8'h80
`define LFCC_FRAME_DIV_BITS 8
`define LFCC_FRAME_LAST 2'h3
`define LFCC_FRAME_LAST_THIRD 2'h2
`endif

//--- logic/lfcc_pkg.sv
// types shared by the panel control block
// assumes nothing outside itself
package lfcc_pkg;
   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } lfcc_bus_req_t;
   typedef struct packed {
      logic supply_on;
      logic running;
      logic show_ram;
      logic op_clk_en;
   } lfcc_drive_t;
   typedef enum logic [2:0] {
      LFCC_HALT = 3'h1,
      LFCC_RUN_SUB = 3'h2,
      LFCC_RUN_SYS = 3'h4
   } lfcc_state_t;
endpackage

//--- logic/lfcc_prescaler.sv
// prescaler giving one-cycle enables at a selected division of a source tick
// assumes src_tick is a same-domain pulse; cleared while halted
module lfcc_prescaler (
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   input wire logic ce,
   // control
   input wire logic run,
   input wire logic src_tick,
   input wire logic [3:0] div_log2,
   // output
   output logic tick_out
);
   logic [7:0] cnt_r;
   logic [7:0] cnt_nxt;
   logic [7:0] low_ones;
   logic wrap;

   // wrap when the low div_log2 bits are all ones; eight needs the whole byte
   assign low_ones = 8'hff >> (4'd8 - div_log2);
   assign wrap = src_tick && ((cnt_r | ~low_ones) == 8'hff);
   assign cnt_nxt = run ? (src_tick ? cnt_r + 8'h01 : cnt_r) : 8'h00;
   assign tick_out = run && wrap;

   // counter frozen by ce
   always_ff @(posedge clk) begin
      if (!resetn) begin
         cnt_r <= 8'h00;
      end else if (ce) begin
         cnt_r <= cnt_nxt;
      end
   end
endmodule

//--- logic/lfcc_top.sv
// panel control register and frame clock selection for the segment display
// assumes a plain register port on clk; subclock and standby arrive from other domains
// Operation
// (RL1) top register bit reads one; writes to it have no effect
// (RL2) drive supply follows supply switch bit, reset zero
// (RL3) supply forced off when run enable low or in standby
// (RL4) controller halted while run enable zero, reset zero
// (RL5) halting keeps all register contents
// (RL6) blank segment data unless show-RAM bit set
// (RL7) select top bit zero: subclock divided by 1, 2 or 4
// (RL8) select top bit one: system clock divided 2 to 256
// (RL9) no display in low power modes when system clock selected
// (RL10) software picks a subclock option before low power modes
// (RL11) one-third duty gives four-thirds frame frequency
// (RL12) writes land on the next edge, reserved bit stays one
module lfcc_top (
   // clock, reset, enable
   input wire logic clk,
   input wire logic resetn,
   input wire logic ce,
   // register port
   input wire logic [3:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [7:0] rdata,
   // asynchronous inputs
   input wire logic subclk_pin,
   input wire logic standby_pin,
   input wire logic sysclk_halted_pin,
   // duty from the neighbouring duty register
   input wire logic third_duty,
   // panel side
   input wire logic [7:0] ram_data,
   output logic drive_supply_on,
   output logic frame_tick,
   output logic [7:0] seg_data,
   output logic running
);
`include "lfcc_regs.svh"
   lfcc_pkg::lfcc_bus_req_t req;
   lfcc_pkg::lfcc_drive_t drv;
   lfcc_pkg::lfcc_state_t state_r;
   lfcc_pkg::lfcc_state_t state_nxt;
   logic [7:0] panel_control_reg_r;
   logic [7:0] rdata_r;
   logic [2:0] sub_sync_r;
   logic [1:0] stby_sync_r;
   logic [1:0] halt_sync_r;
   logic [1:0] third_cnt_r;
   logic [7:0] seg_r;
   logic supply_r;
   logic tick_r;
   logic drive_supply_switch;
   logic controller_run_enable;
   logic show_ram_contents;
   logic [3:0] frame_clock_select;
   logic sub_tick;
   logic sys_tick;
   logic src_tick;
   logic pre_tick;
   logic [3:0] div_log2;
   logic sel_ctrl;
   logic sel_lo;
   logic sel_stat;
   logic stand;
   logic sys_halted;
   logic [1:0] frame_last;
   logic frame_end;

   assign req = '{addr: addr, wdata: wdata, wr: wr, rd: rd};
   assign drive_supply_switch = panel_control_reg_r[`LFCC_PSW_BIT];
   assign controller_run_enable = panel_control_reg_r[`LFCC_RUN_BIT];
   assign show_ram_contents = panel_control_reg_r[`LFCC_SHOW_BIT];
   assign frame_clock_select = panel_control_reg_r[`LFCC_CKS_MSB:0];
   assign stand = stby_sync_r[1];
   assign sys_halted = halt_sync_r[1];

   // address decode
   assign sel_ctrl = req.addr == `LFCC_PANEL_CONTROL_OFS;
   assign sel_lo = req.addr == `LFCC_SEL_LO_OFS;
   assign sel_stat = req.addr == `LFCC_STATUS_OFS;

   // two-flop synchronisers; third stage only feeds the edge detector
   always_ff @(posedge clk) begin
      if (!resetn) begin
         sub_sync_r <= 3'h0;
         stby_sync_r <= 2'h0;
         halt_sync_r <= 2'h0;
      end else if (ce) begin
         sub_sync_r <= {sub_sync_r[1:0], subclk_pin};
         stby_sync_r <= {stby_sync_r[0], standby_pin};
         halt_sync_r <= {halt_sync_r[0], sysclk_halted_pin};
      end
   end
   assign sub_tick = sub_sync_r[1] && !sub_sync_r[2];
   assign sys_tick = !sys_halted;

   // (RL7) subclock divided by 1, 2 or 4
   // (RL8) system clock divided by 2 up to 256
   assign div_log2 = frame_clock_select[3] ? {1'b0, frame_clock_select[2:0]} + 4'h1 :
                     (frame_clock_select[1] ? 4'h2 : {3'h0, frame_clock_select[0]});
   assign src_tick = frame_clock_select[3] ? sys_tick : sub_tick;

   // state from run enable and clock source
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         lfcc_pkg::LFCC_HALT: begin
            if (controller_run_enable)
               state_nxt = frame_clock_select[3] ? lfcc_pkg::LFCC_RUN_SYS : lfcc_pkg::LFCC_RUN_SUB;
         end
         lfcc_pkg::LFCC_RUN_SUB, lfcc_pkg::LFCC_RUN_SYS: begin
            if (!controller_run_enable)
               state_nxt = lfcc_pkg::LFCC_HALT;
            else
               state_nxt = frame_clock_select[3] ? lfcc_pkg::LFCC_RUN_SYS : lfcc_pkg::LFCC_RUN_SUB;
         end
         default: state_nxt = lfcc_pkg::LFCC_HALT;
      endcase
   end

   // (RL4) halted state stops the prescaler
   // (RL9) system clock source gives nothing while it is halted
   assign drv.running = state_r != lfcc_pkg::LFCC_HALT && !stand;
   assign drv.op_clk_en = drv.running && !(state_r == lfcc_pkg::LFCC_RUN_SYS && sys_halted);
   // (RL2) (RL3) supply gated by run enable and standby
   // follows the run state so supply never leads the controller
   assign drv.supply_on = drive_supply_switch && controller_run_enable && drv.running;
   // (RL6) blank unless show bit set
   assign drv.show_ram = show_ram_contents && drv.running;

   lfcc_prescaler u_pre (
      .clk(clk),
      .resetn(resetn),
      .ce(ce),
      .run(drv.op_clk_en),
      .src_tick(src_tick),
      .div_log2(div_log2),
      .tick_out(pre_tick)
   );

   // (RL11) frame of three operating periods at third duty, four otherwise
   assign frame_last = third_duty ? `LFCC_FRAME_LAST_THIRD : `LFCC_FRAME_LAST;
   assign frame_end = pre_tick && third_cnt_r >= frame_last;

   // register write; contents kept while halted
   always_ff @(posedge clk) begin
      if (!resetn) begin
         panel_control_reg_r <= `LFCC_PANEL_CONTROL_RST;
         state_r <= lfcc_pkg::LFCC_HALT;
      end else if (ce) begin
         state_r <= state_nxt;
         // (RL1) (RL12) write lands next edge, top bit stays one
         // (RL5) halting touches no bit of the control register
         if (req.wr && sel_ctrl)
            panel_control_reg_r <= req.wdata | `LFCC_RSVD_MASK;
         else if (req.wr && sel_lo)
            panel_control_reg_r <= {panel_control_reg_r[7:4], req.wdata[3:0]};
      end
   end

   // frame tick, supply and segment outputs from flops
   always_ff @(posedge clk) begin
      if (!resetn) begin
         third_cnt_r <= 2'h0;
         tick_r <= 1'b0;
         supply_r <= 1'b0;
         seg_r <= 8'h00;
      end else if (ce) begin
         // frame restarts whenever the operating clock stops
         if (!drv.op_clk_en)
            third_cnt_r <= 2'h0;
         else if (pre_tick)
            third_cnt_r <= frame_end ? 2'h0 : third_cnt_r + 2'h1;
         tick_r <= frame_end;
         supply_r <= drv.supply_on;
         seg_r <= drv.show_ram ? ram_data : 8'h00;
      end
   end

   // read data one cycle after strobe; unmapped reads zero
   always_ff @(posedge clk) begin
      if (!resetn) begin
         rdata_r <= 8'h00;
      end else if (ce) begin
         if (req.rd && sel_ctrl)
            rdata_r <= panel_control_reg_r;
         else if (req.rd && sel_lo)
            rdata_r <= {4'h0, frame_clock_select};
         else if (req.rd && sel_stat)
            rdata_r <= {4'h0, drv.supply_on, drv.running, drv.op_clk_en, sys_halted};
         else
            rdata_r <= 8'h00;
      end
   end

   assign rdata = rdata_r;
   assign drive_supply_on = supply_r;
   assign frame_tick = tick_r;
   assign seg_data = seg_r;
   assign running = drv.running;
endmodule

//--- verif/lfcc_top_props.sv
// port assertions for the panel control block
// assumes one clock and a synchronous active-low reset
module lfcc_top_props (
   // clock and reset
   input wire logic clk, input wire logic resetn,
   // register port
   input wire logic [3:0] addr, input wire logic [7:0] wdata, input wire logic wr,
   input wire logic rd, input wire logic [7:0] rdata,
   // asynchronous levels and panel side
   input wire logic subclk_pin, input wire logic standby_pin, input wire logic sysclk_halted_pin,
   input wire logic [7:0] ram_data, input wire logic drive_supply_on, input wire logic frame_tick,
   input wire logic [7:0] seg_data, input wire logic running
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   a_rsvd_reads_one: assert property (rd && addr == 4'h0 |=> rdata[7] == 1'b1)
      else $error("top bit read as zero");
   a_write_lands: assert property (wr && addr == 4'h0 ##1 !wr ##1 rd && addr == 4'h0
      |=> rdata == ($past(wdata, 3) | 8'h80)) else $error("written byte not read back");
   a_supply_needs_run: assert property (drive_supply_on |-> $past(running))
      else $error("supply on while halted");
   a_standby_cuts: assert property (standby_pin [*4] |-> !drive_supply_on)
      else $error("supply on in standby");
   a_halt_no_tick: assert property (!running [*2] |-> !frame_tick)
      else $error("frame tick while halted");
   a_blank_segs: assert property (seg_data != 8'h00 |-> seg_data == $past(ram_data))
      else $error("segments not from display data");
   // no subclock edge and no system clock: nothing may drive a frame
   a_sys_halt_still: assert property ((sysclk_halted_pin && $stable(subclk_pin)) [*8] |-> !frame_tick)
      else $error("frame tick without a running source");
   a_tick_spacing: assert property (frame_tick |=> !frame_tick)
      else $error("frame ticks back to back");
endmodule
bind lfcc_top lfcc_top_props i_props (.clk, .resetn, .addr, .wdata, .wr, .rd, .rdata, .subclk_pin,
   .standby_pin, .sysclk_halted_pin, .ram_data, .drive_supply_on, .frame_tick, .seg_data, .running);

//--- verif/lfcc_panel_model.sv
// behavioural segment panel: counts frames that reach it
// assumes the controller clock; an unpowered panel sees no frames
module lfcc_panel_model (
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   // electrode side
   input wire logic supply_on,
   input wire logic frame_tick,
   // observation
   output int frames
);
   timeunit 1ns;
   timeprecision 1ns;
   // frames only count while the drive supply is up
   always @(posedge clk) begin
      if (!resetn) frames <= 0;
      else if (supply_on && frame_tick === 1'b1) frames <= frames + 1;
   end
endmodule

//--- verif/test_lcd_frame_clock_control.sv
// self-checking bench for the panel control block
// assumes lfcc_top, its package and the panel model compiled before it
module test_lcd_frame_clock_control;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'b0, resetn = 1'b0, ce = 1'b1, wr = 1'b0, rd = 1'b0, subclk_pin = 1'b0, sub_run = 1'b0;
   logic standby_pin = 1'b0, sysclk_halted_pin = 1'b0, third_duty = 1'b0, drive_supply_on, frame_tick, running;
   logic [3:0] addr = 4'h0;
   logic [7:0] wdata = 8'h00, ram_data = 8'ha5, rdata, seg_data;
   int errors = 0, n_tests = 0, frames, f0;
   always #25 clk = ~clk;
   // watch crystal stand-in, sixteen system cycles a period
   always begin
      repeat (8) @(posedge clk);
      if (sub_run) subclk_pin <= ~subclk_pin;
   end
   lfcc_top i_dut (.clk, .resetn, .ce, .addr, .wdata, .wr, .rd, .rdata, .subclk_pin, .standby_pin,
      .sysclk_halted_pin, .third_duty, .ram_data, .drive_supply_on, .frame_tick, .seg_data, .running);
   lfcc_panel_model i_panel (.clk, .resetn, .supply_on(drive_supply_on), .frame_tick, .frames);
   task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         errors++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic wr_reg(logic [3:0] a, logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rd_reg(logic [3:0] a, logic [7:0] exp);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 check("rdata", rdata, exp);
   endtask
   // bounded wait so a dead prescaler cannot hang the run
   task automatic next_tick(output int n);
      n = 0;
      do begin
         @(posedge clk);
         #1 n++;
      end while (frame_tick !== 1'b1 && n < 2000);
   endtask
   // first periods after a select change may be short, so measure the third
   task automatic gap(logic [3:0] sel, int exp);
      int n;
      wr_reg(4'h0, {4'h7, sel});
      repeat (3) next_tick(n);
      check("tick gap", n, exp);
   endtask
   task automatic t_fields();
      rd_reg(4'h0, 8'h80);
      check("supply", drive_supply_on, 1'b0);
      check("running", running, 1'b0);
      wr_reg(4'h0, 8'h60);
      @(posedge clk);
      #1 check("running", running, 1'b1);
      rd_reg(4'h0, 8'he0);
      check("supply", drive_supply_on, 1'b1);
      check("blank", seg_data, 8'h00);
      wr_reg(4'h0, 8'h70);
      repeat (2) @(posedge clk);
      #1 check("segments", seg_data, 8'ha5);
      wr_reg(4'h0, 8'h50);
      repeat (2) @(posedge clk);
      #1 check("supply", drive_supply_on, 1'b0);
      check("running", running, 1'b0);
      rd_reg(4'h0, 8'hd0);
      rd_reg(4'h5, 8'h00);
      $display("fields test done");
   endtask
   task automatic t_standby();
      wr_reg(4'h0, 8'h60);
      standby_pin <= 1'b1;
      repeat (4) @(posedge clk);
      #1 check("standby", drive_supply_on, 1'b0);
      standby_pin <= 1'b0;
      repeat (4) @(posedge clk);
      #1 check("standby", drive_supply_on, 1'b1);
      $display("standby test done");
   endtask
   task automatic t_clocks();
      sub_run <= 1'b1;
      for (int k = 0; k < 8; k++) gap(4'h8 + 4'(k), 8 << k);
      for (int k = 0; k < 4; k++) gap(4'(k), 64 << (k - k / 3));
      // subclock option is already chosen before the system clock stops
      sysclk_halted_pin <= 1'b1;
      gap(4'h1, 128);
      wr_reg(4'h0, 8'h78);
      sub_run <= 1'b0;
      repeat (20) @(posedge clk);
      f0 = frames;
      repeat (300) @(posedge clk);
      check("halted frames", frames - f0, 0);
      sysclk_halted_pin <= 1'b0;
      sub_run <= 1'b1;
      $display("clock test done");
   endtask
   task automatic t_third();
      third_duty <= 1'b1;
      wr_reg(4'h0, 8'h78);
      repeat (20) @(posedge clk);
      f0 = frames;
      repeat (240) @(posedge clk);
      check("third duty frames", frames - f0, 40);
      gap(4'h9, 12);
      $display("duty test done");
   endtask
   initial begin
      repeat (6) @(posedge clk);
      resetn <= 1'b1;
      t_fields();
      t_standby();
      t_clocks();
      t_third();
      report_and_stop();
   end
   initial begin
      repeat (40000) @(posedge clk);
      errors++;
      $display("Error watchdog expired");
      report_and_stop();
   end
endmodule
